// >>> def_stage.sv
`timescale 1ns/1ns
module def_stage (
  input wire logic clk,
  input wire logic rst,
  input wire logic ext_block,
  input wire logic force_enable,
  input wire logic force_block,
  input wire logic inrush_enable,
  input wire logic [12:0] inrush_limit,
  input wire logic [12:0] harm_ratio,
  input wire logic [2:0] grounding,
  input wire logic mcd_enable,
  input wire logic divider_enable,
  input wire logic [1:0] u0_channel,
  input wire logic phase_neutral_wired,
  input wire logic seq_fault,
  input wire logic current_pickup,
  input wire logic [31:0] u0_meas,
  input wire logic [31:0] u0_pickup,
  input wire logic [17:0] i0_mag,
  input wire logic [17:0] i0_set,
  input wire logic signed [15:0] angle,
  input wire logic signed [15:0] cos_q15,
  input wire logic signed [15:0] sin_q15,
  input wire logic idmt_mode,
  input wire logic [18:0] delay_steps,
  input wire logic [18:0] release_steps,
  output logic [1:0] condition,
  output logic [1:0] u0_source,
  output logic [1:0] direction,
  output logic signed [18:0] wattmetric_component,
  output logic signed [18:0] varmetric_component,
  output logic [17:0] ratio,
  output logic signed [15:0] divider_angle,
  output logic [18:0] expected_steps,
  output logic [18:0] remain_steps,
  output logic start_out,
  output logic trip_out,
  output logic blocked_out,
  output logic start_on,
  output logic start_off,
  output logic trip_on,
  output logic trip_off,
  output logic block_on,
  output logic block_off,
  output logic block_event,
  output logic [17:0] event_current,
  output logic [2:0] event_fault_type
);
  // ==========================================================
  // program cycle tick
  typedef enum {ST_IDLE, ST_TIMING, ST_TRIPPED, ST_BLOCKED, ST_RELEASE}
    stage_t;
  localparam int CYC_W_L = def_pkg::CYC_W;
  stage_t st_r;
  logic [CYC_W_L-1:0] cyc_r;
  logic cyc_end;
  logic tick_r;
  logic tick_d_r;
  logic blk_r;
  logic [18:0] cnt_r;
  logic [18:0] rel_r;

  assign cyc_end = cyc_r == CYC_W_L'(def_pkg::STEP_CYC - 1);

  always_ff @(posedge clk) begin
    if (rst) begin
      cyc_r <= '0;
      tick_r <= 1'b0;
    end else if (cyc_end) begin
      cyc_r <= '0;
      tick_r <= 1'b1;
    end else begin
      cyc_r <= cyc_r + 1'b1;
      tick_r <= 1'b0;
    end
  end

  // ==========================================================
  // block sample at cycle start
  logic inrush_blk;
  assign inrush_blk = inrush_enable && (harm_ratio > inrush_limit);

  always_ff @(posedge clk) begin
    if (rst) begin
      blk_r <= 1'b0;
    end else if (cyc_end) begin
      // sampled just ahead of the tick that evaluates pick-up
      blk_r <= (force_enable ? force_block : ext_block)
        | inrush_blk;
    end
  end

  // state settles one cycle after the tick, events look then
  always_ff @(posedge clk) begin
    if (rst) begin
      tick_d_r <= 1'b0;
    end else begin
      tick_d_r <= tick_r;
    end
  end

  // ==========================================================
  // direction and pick-up
  logic signed [15:0] div_nxt;
  logic [1:0] dir_nxt;
  logic [1:0] src_nxt;
  logic pickup;
  logic fourth_q;
  logic signed [15:0] ref_ang;
  logic signed [15:0] diff;

  always_comb begin
    div_nxt = divider_enable ? def_pkg::DIVIDER_DEFAULT
                             : def_pkg::DIVIDER_OFF;
    case (grounding)
      def_pkg::GND_UNEARTHED: ref_ang = -def_pkg::ANG_90;
      def_pkg::GND_COMPENSATED: ref_ang = def_pkg::ANG_180;
      def_pkg::GND_SOLID: ref_ang = -def_pkg::ANG_90;
      default: ref_ang = -(def_pkg::ANG_90 - div_nxt);
    endcase
    diff = angle - ref_ang;
    fourth_q = (angle < 16'sh0000) && (angle > -def_pkg::ANG_90);
    if (i0_mag == '0) begin
      dir_nxt = def_pkg::DIR_UNDEF;
    end else if (diff < def_pkg::ANG_TOL && diff > -def_pkg::ANG_TOL) begin
      dir_nxt = def_pkg::DIR_FWD;
    end else begin
      dir_nxt = def_pkg::DIR_REV;
    end
    if (u0_channel == 2'h2) begin
      src_nxt = def_pkg::SRC_CH3;
    end else if (u0_channel == 2'h3) begin
      src_nxt = def_pkg::SRC_CH4;
    end else if (u0_channel == 2'h1 || phase_neutral_wired) begin
      src_nxt = def_pkg::SRC_CALC;
    end else begin
      src_nxt = def_pkg::SRC_NONE;
    end
    pickup = current_pickup && (u0_meas > u0_pickup)
      && (src_nxt != def_pkg::SRC_NONE) && (dir_nxt == def_pkg::DIR_FWD);
    if (grounding == def_pkg::GND_BROAD && mcd_enable) begin
      pickup = pickup && fourth_q && seq_fault;
    end
  end

  // ==========================================================
  // stage sequence
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= ST_IDLE;
      cnt_r <= '0;
      rel_r <= '0;
    end else if (tick_r) begin
      case (st_r)
        ST_IDLE, ST_RELEASE: begin
          if (pickup && blk_r) begin
            st_r <= ST_BLOCKED;
          end else if (pickup) begin
            st_r <= ST_TIMING;
            if (st_r == ST_IDLE) begin
              cnt_r <= delay_steps;
            end
          end else if (st_r == ST_RELEASE) begin
            if (rel_r == '0) begin
              st_r <= ST_IDLE;
              cnt_r <= '0;
            end else begin
              rel_r <= rel_r - 1'b1;
            end
          end
        end
        ST_TIMING: begin
          if (blk_r || !pickup) begin
            st_r <= blk_r && pickup ? ST_BLOCKED : ST_RELEASE;
            rel_r <= release_steps;
          end else if (cnt_r <= 19'h00001) begin
            st_r <= ST_TRIPPED;
            cnt_r <= '0;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        ST_TRIPPED: begin
          if (!pickup || blk_r) begin
            st_r <= ST_IDLE;
          end
        end
        ST_BLOCKED: begin
          if (!pickup || !blk_r) begin
            st_r <= ST_IDLE;
            cnt_r <= '0;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // indications
  logic [35:0] ratio_w;
  logic signed [34:0] watt_w;
  logic signed [34:0] var_w;
  logic [18:0] exp_nxt;
  assign ratio_w = (i0_set == '0) ? '0
    : (36'(i0_mag) * 36'(def_pkg::PU_SCALE)) / 36'(i0_set);
  assign watt_w = $signed({1'b0, i0_mag}) * cos_q15;
  assign var_w = $signed({1'b0, i0_mag}) * sin_q15;
  assign exp_nxt = (idmt_mode && ratio_w >= 36'(def_pkg::PU_SCALE))
    ? 19'((36'(delay_steps) * 36'(def_pkg::PU_SCALE)) / ratio_w)
    : delay_steps;

  always_ff @(posedge clk) begin
    if (rst) begin
      condition <= def_pkg::COND_NORMAL;
      u0_source <= def_pkg::SRC_NONE;
      direction <= def_pkg::DIR_UNDEF;
      wattmetric_component <= '0;
      varmetric_component <= '0;
      ratio <= '0;
      divider_angle <= def_pkg::DIVIDER_DEFAULT;
      expected_steps <= '0;
      remain_steps <= '0;
      start_out <= 1'b0;
      trip_out <= 1'b0;
      blocked_out <= 1'b0;
    end else begin
      case (st_r)
        ST_TIMING: condition <= def_pkg::COND_START;
        ST_TRIPPED: condition <= def_pkg::COND_TRIP;
        ST_BLOCKED: condition <= def_pkg::COND_BLOCKED;
        default: condition <= def_pkg::COND_NORMAL;
      endcase
      u0_source <= src_nxt;
      direction <= dir_nxt;
      wattmetric_component <= watt_w[33:15];
      varmetric_component <= var_w[33:15];
      ratio <= 18'(ratio_w > 36'h00003FFFF ? 36'h00003FFFF : ratio_w);
      divider_angle <= div_nxt;
      expected_steps <= exp_nxt > def_pkg::MAX_STEPS
        ? def_pkg::MAX_STEPS : exp_nxt;
      remain_steps <= (st_r == ST_TIMING) ? cnt_r : '0;
      start_out <= st_r == ST_TIMING;
      trip_out <= st_r == ST_TRIPPED;
      blocked_out <= st_r == ST_BLOCKED;
    end
  end

  // ==========================================================
  // events
  def_evt_if ev_s ();
  def_evt_if ev_t ();
  def_evt_if ev_b ();
  assign ev_s.level = st_r == ST_TIMING;
  assign ev_t.level = st_r == ST_TRIPPED;
  assign ev_b.level = st_r == ST_BLOCKED;
  def_edge_evt u_es (.clk(clk), .rst(rst), .tick(tick_d_r), .ev(ev_s));
  def_edge_evt u_et (.clk(clk), .rst(rst), .tick(tick_d_r), .ev(ev_t));
  def_edge_evt u_eb (.clk(clk), .rst(rst), .tick(tick_d_r), .ev(ev_b));

  always_ff @(posedge clk) begin
    if (rst) begin
      start_on <= 1'b0;
      start_off <= 1'b0;
      trip_on <= 1'b0;
      trip_off <= 1'b0;
      block_on <= 1'b0;
      block_off <= 1'b0;
      block_event <= 1'b0;
      event_current <= '0;
      event_fault_type <= '0;
    end else begin
      start_on <= ev_s.on_pulse;
      start_off <= ev_s.off_pulse;
      trip_on <= ev_t.on_pulse;
      trip_off <= ev_t.off_pulse;
      block_on <= ev_b.on_pulse;
      block_off <= ev_b.off_pulse;
      block_event <= ev_b.on_pulse;
      if (ev_b.on_pulse) begin
        event_current <= i0_mag;
        event_fault_type <= grounding;
      end
    end
  end

  // ==========================================================
  // checks
  property p_blk_no_start;
    @(posedge clk) disable iff (rst)
      tick_r && pickup && blk_r && st_r == ST_IDLE
      |=> ##1 blocked_out && !start_out;
  endproperty
  a_blk_no_start: assert property (p_blk_no_start)
    else $error("blocked pick-up started");
  property p_start;
    @(posedge clk) disable iff (rst)
      tick_r && pickup && !blk_r && st_r == ST_IDLE
      |=> ##1 start_out && condition == def_pkg::COND_START;
  endproperty
  a_start: assert property (p_start)
    else $error("start missing");
  property p_drop;
    @(posedge clk) disable iff (rst)
      tick_r && st_r == ST_TIMING && blk_r |=> ##1 !start_out;
  endproperty
  a_drop: assert property (p_drop)
    else $error("start not dropped");
  property p_div;
    @(posedge clk) disable iff (rst)
      !divider_enable |=> divider_angle == def_pkg::DIVIDER_OFF;
  endproperty
  a_div: assert property (p_div)
    else $error("divider not zero");
  property p_src;
    @(posedge clk) disable iff (rst)
      u0_channel == 2'h0 && !phase_neutral_wired
      |=> u0_source == def_pkg::SRC_NONE;
  endproperty
  a_src: assert property (p_src)
    else $error("source not none");
  property p_bev;
    @(posedge clk) disable iff (rst)
      $rose(blocked_out) |-> ##[0:2] block_event;
  endproperty
  a_bev: assert property (p_bev)
    else $error("block event missing");
  property p_sample;
    @(posedge clk) disable iff (rst)
      !cyc_end |=> $stable(blk_r);
  endproperty
  a_sample: assert property (p_sample)
    else $error("block sampled mid cycle");
  property p_remain;
    @(posedge clk) disable iff (rst)
      !start_out |-> remain_steps == '0 || $past(st_r) == ST_TIMING;
  endproperty
  a_remain: assert property (p_remain)
    else $error("remain shown while idle");
endmodule

// >>> def_pkg.sv
package def_pkg;
  // ==========================================================
  // encodings
  localparam logic [1:0] COND_NORMAL = 2'h0;
  localparam logic [1:0] COND_START = 2'h1;
  localparam logic [1:0] COND_TRIP = 2'h2;
  localparam logic [1:0] COND_BLOCKED = 2'h3;
  localparam logic [1:0] SRC_NONE = 2'h0;
  localparam logic [1:0] SRC_CALC = 2'h1;
  localparam logic [1:0] SRC_CH3 = 2'h2;
  localparam logic [1:0] SRC_CH4 = 2'h3;
  localparam logic [1:0] DIR_UNDEF = 2'h0;
  localparam logic [1:0] DIR_FWD = 2'h1;
  localparam logic [1:0] DIR_REV = 2'h2;
  localparam logic [2:0] GND_UNEARTHED = 3'h1;
  localparam logic [2:0] GND_COMPENSATED = 3'h2;
  localparam logic [2:0] GND_SOLID = 3'h3;
  localparam logic [2:0] GND_BROAD = 3'h4;
  // ==========================================================
  // angles in 0.1 degree, signed
  localparam logic signed [15:0] DIVIDER_DEFAULT = 16'sh01C2;
  localparam logic signed [15:0] DIVIDER_OFF = 16'sh0000;
  localparam logic signed [15:0] ANG_90 = 16'sh0384;
  localparam logic signed [15:0] ANG_180 = 16'sh0708;
  localparam logic signed [15:0] ANG_TOL = 16'sh0384;
  // ==========================================================
  // timing: program cycle 5 ms at 10 MHz, 5 ms per time step
  localparam int CLK_HZ = 10000000;
  localparam int STEP_US = 5000;
  localparam int STEP_CYC = CLK_HZ / 1000000 * STEP_US;
  localparam logic [18:0] MAX_STEPS = 19'h57E40;
  localparam int CYC_W = 16;
  localparam int PU_SCALE = 1000;
endpackage

// >>> def_evt_if.sv
`timescale 1ns/1ns
interface def_evt_if;
  logic level;
  logic on_pulse;
  logic off_pulse;
  modport src (output level);
  modport det (input level, output on_pulse, output off_pulse);
endinterface

// >>> def_edge_evt.sv
`timescale 1ns/1ns
module def_edge_evt (
  input wire logic clk,
  input wire logic rst,
  input wire logic tick,
  def_evt_if.det ev
);
  // ==========================================================
  // on/off event pulse per status change
  logic prev_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      prev_r <= 1'b0;
      ev.on_pulse <= 1'b0;
      ev.off_pulse <= 1'b0;
    end else begin
      ev.on_pulse <= tick & ev.level & ~prev_r;
      ev.off_pulse <= tick & ~ev.level & prev_r;
      if (tick) begin
        prev_r <= ev.level;
      end
    end
  end

  property p_on;
    @(posedge clk) disable iff (rst)
      tick && ev.level && !prev_r |=> ev.on_pulse && !ev.off_pulse;
  endproperty
  a_on: assert property (p_on)
    else $error("on event missing");
  property p_off;
    @(posedge clk) disable iff (rst)
      tick && !ev.level && prev_r |=> ev.off_pulse;
  endproperty
  a_off: assert property (p_off)
    else $error("off event missing");
endmodule

// >>> def_channel_model.sv
`timescale 1ns/1ns
// ==========================================================
// blocking matrix and measured channels of the feeder
module def_channel_model (
  input wire logic block_req,
  input wire logic [17:0] i0_req,
  output logic ext_block,
  output logic [17:0] i0_mag,
  output logic [31:0] u0_meas,
  output logic signed [15:0] angle,
  output logic signed [15:0] cos_q15,
  output logic signed [15:0] sin_q15,
  output logic seq_fault
);
  logic flt;
  assign flt = (i0_req != 18'h00000);
  // block follows the request, well ahead of any delay end
  assign ext_block = block_req;
  // residual current follows the request, voltage supplied only while i0_req is non-zero
  assign i0_mag = i0_req;
  assign u0_meas = flt ? 32'h00001000 : 32'h00000000;
  // capacitive fault: current lags voltage by 90 degrees
  assign angle = flt ? -16'sh0384 : 16'sh0000;
  assign cos_q15 = 16'sh0000;
  assign sin_q15 = flt ? 16'sh8000 : 16'sh0000;
  assign seq_fault = flt;
endmodule

// >>> test_dir_earth_fault_block_status.sv
`timescale 1ns/1ns
// ==========================================================
// bench for one directional residual stage
module test_dir_earth_fault_block_status;
  logic clk, rst, block_req, force_enable, force_block, inrush_enable;
  logic [12:0] inrush_limit, harm_ratio;
  logic [2:0] grounding;
  logic mcd_enable, divider_enable, phase_neutral_wired, current_pickup;
  logic [1:0] u0_channel;
  logic [31:0] u0_pickup;
  logic [17:0] i0_req, i0_set;
  logic idmt_mode, use_force;
  logic [18:0] delay_steps, release_steps;
  logic ext_block, seq_fault;
  logic [17:0] i0_mag;
  logic [31:0] u0_meas;
  logic signed [15:0] angle, cos_q15, sin_q15;
  logic [1:0] condition, u0_source, direction;
  logic signed [18:0] wattmetric_component, varmetric_component;
  logic [17:0] ratio, event_current;
  logic signed [15:0] divider_angle;
  logic [18:0] expected_steps, remain_steps;
  logic start_out, trip_out, blocked_out, start_on, start_off;
  logic trip_on, trip_off, block_on, block_off, block_event;
  logic [2:0] event_fault_type;
  int mismatches = 0;
  int n_compared = 0;
  int cyc = 0;
  int n, t_start;

  def_channel_model partner (.block_req(block_req), .i0_req(i0_req),
    .ext_block(ext_block), .i0_mag(i0_mag), .u0_meas(u0_meas),
    .angle(angle), .cos_q15(cos_q15), .sin_q15(sin_q15),
    .seq_fault(seq_fault));

  def_stage dut (.clk(clk), .rst(rst), .ext_block(ext_block),
    .force_enable(force_enable), .force_block(force_block),
    .inrush_enable(inrush_enable), .inrush_limit(inrush_limit),
    .harm_ratio(harm_ratio), .grounding(grounding),
    .mcd_enable(mcd_enable), .divider_enable(divider_enable),
    .u0_channel(u0_channel), .phase_neutral_wired(phase_neutral_wired),
    .seq_fault(seq_fault), .current_pickup(current_pickup),
    .u0_meas(u0_meas), .u0_pickup(u0_pickup), .i0_mag(i0_mag),
    .i0_set(i0_set), .angle(angle), .cos_q15(cos_q15), .sin_q15(sin_q15),
    .idmt_mode(idmt_mode), .delay_steps(delay_steps),
    .release_steps(release_steps), .condition(condition),
    .u0_source(u0_source), .direction(direction),
    .wattmetric_component(wattmetric_component),
    .varmetric_component(varmetric_component), .ratio(ratio),
    .divider_angle(divider_angle), .expected_steps(expected_steps),
    .remain_steps(remain_steps), .start_out(start_out),
    .trip_out(trip_out), .blocked_out(blocked_out), .start_on(start_on),
    .start_off(start_off), .trip_on(trip_on), .trip_off(trip_off),
    .block_on(block_on), .block_off(block_off),
    .block_event(block_event), .event_current(event_current),
    .event_fault_type(event_fault_type));

  // ==========================================================
  // expectations
  function automatic logic [1:0] exp_src(input logic [1:0] ch,
                                         input logic pn);
    if (ch != def_pkg::SRC_NONE) return ch;
    return pn ? def_pkg::SRC_CALC : def_pkg::SRC_NONE;
  endfunction

  function automatic logic signed [15:0] exp_div(input logic en);
    return en ? def_pkg::DIVIDER_DEFAULT : def_pkg::DIVIDER_OFF;
  endfunction

  function automatic logic [18:0] exp_time(input logic idmt,
                                           input logic [18:0] d,
                                           input logic [17:0] r);
    if (idmt && r >= 18'(def_pkg::PU_SCALE))
      return 19'(int'(d) * def_pkg::PU_SCALE / int'(r));
    return d;
  endfunction

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ==========================================================
  // clock and timeout
  always #50 clk = ~clk;

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2 * def_pkg::STEP_CYC + 2000) begin
      mismatches++;
      wrap_up();
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    block_req = 1'b0;
    i0_req = 18'h00000;
    force_enable = 1'b0;
    force_block = 1'b0;
    inrush_enable = 1'b0;
    inrush_limit = 13'h03E8;
    harm_ratio = 13'h0000;
    grounding = def_pkg::GND_UNEARTHED;
    mcd_enable = 1'b0;
    divider_enable = 1'b0;
    u0_channel = 2'h0;
    phase_neutral_wired = 1'b0;
    current_pickup = 1'b0;
    u0_pickup = 32'h00000100;
    i0_set = 18'h003E8;
    idmt_mode = 1'b0;
    delay_steps = 19'h00064;
    release_steps = 19'h00000;
    use_force = 1'b0;
    void'($urandom(32'h191D90C0));
    repeat (2) @(negedge clk);
    check("divider reset", divider_angle, def_pkg::DIVIDER_DEFAULT);
    check("condition reset", condition, def_pkg::COND_NORMAL);
    rst = 1'b0;
    @(posedge clk);
    #1;
    check("divider off", divider_angle, def_pkg::DIVIDER_OFF);
    @(negedge clk);
    u0_channel = 2'($urandom % 4);
    phase_neutral_wired = 1'($urandom % 2) | (u0_channel == 2'h0);
    divider_enable = 1'($urandom % 2);
    inrush_enable = 1'($urandom % 2);
    harm_ratio = 13'($urandom % 1000);
    mcd_enable = 1'($urandom % 2);
    idmt_mode = 1'($urandom % 2);
    delay_steps = 19'(50 + $urandom % 1000);
    release_steps = 19'($urandom % 20);
    use_force = 1'($urandom % 2);
    i0_req = 18'(1 + $urandom % 100000);
    current_pickup = 1'b1;
    n = 0;
    while (start_on !== 1'b1 && n < def_pkg::STEP_CYC + 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    t_start = cyc;
    check("start_on", start_on, 1'b1);
    check("start_out", start_out, 1'b1);
    check("condition start", condition, def_pkg::COND_START);
    check("u0_source", u0_source, exp_src(u0_channel,
          phase_neutral_wired));
    check("direction", direction, def_pkg::DIR_FWD);
    check("wattmetric", wattmetric_component, 19'sh00000);
    check("varmetric", varmetric_component, -$signed({1'b0, i0_req}));
    check("ratio", ratio, i0_req);
    check("expected", expected_steps, exp_time(idmt_mode, delay_steps,
          i0_req));
    check("remain", remain_steps, delay_steps);
    check("divider", divider_angle, exp_div(divider_enable));
    check("trip_out", trip_out, 1'b0);
    check("blocked early", blocked_out, 1'b0);
    @(negedge clk);
    if (use_force) begin
      force_enable = 1'b1;
      force_block = 1'b1;
    end else begin
      block_req = 1'b1;
    end
    repeat (10) @(posedge clk);
    #1;
    check("block mid cycle", blocked_out, 1'b0);
    check("condition mid", condition, def_pkg::COND_START);
    n = 0;
    while (block_on !== 1'b1 && n < def_pkg::STEP_CYC + 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("block spacing", cyc - t_start, def_pkg::STEP_CYC);
    check("start_off", start_off, 1'b1);
    check("block_event", block_event, 1'b1);
    check("event_current", event_current, i0_req);
    check("blocked_out", blocked_out, 1'b1);
    check("start dropped", start_out, 1'b0);
    check("condition blocked", condition, def_pkg::COND_BLOCKED);
    check("no trip", trip_on, 1'b0);
    check("fault type", event_fault_type, def_pkg::GND_UNEARTHED);
    check("remain cleared", remain_steps, 19'h00000);
    wrap_up();
  end
endmodule
